// >>> hdl/dofb_pkg.sv
// Package: register map, field positions, reset values and types of the display output stage
`default_nettype none
package dofb_pkg;
  // Register byte offsets from the graphics register base
  localparam logic [15:0] OFF_OUT_CFG = 16'h830C;
  localparam logic [15:0] OFF_FB_START = 16'h8310;
  localparam logic [15:0] OFF_CB_START = 16'h8314;
  localparam logic [15:0] OFF_CUR_START = 16'h8318;
  localparam logic [15:0] OFF_VID_START = 16'h8320;
  localparam logic [15:0] OFF_LINE_DELTA = 16'h8324;
  localparam logic [15:0] OFF_BUF_SIZE = 16'h8328;
  localparam logic [15:0] OFF_STATUS = 16'h8330;
  // Output configuration field positions
  localparam int CFG_UPPER_BIT = 13;
  localparam int CFG_LOWER_BIT = 12;
  localparam int CFG_PCLK_BIT = 2;
  localparam int CFG_FMT_BIT = 1;
  localparam int CFG_DEPTH_BIT = 0;
  // Writable bits of each register; all others read as zero
  localparam logic [31:0] OUT_CFG_MASK = 32'h0000_3007;
  localparam logic [31:0] OFFSET_MASK = 32'h003F_FFFF;
  localparam logic [31:0] DELTA_MASK = 32'h007F_F7FF;
  localparam logic [31:0] BUF_SIZE_MASK = 32'h3FFF_FFFF;
  // Offset and address layout inside the 4 MB aperture
  localparam int APER_W = 22;
  localparam int ADDR_LSB = 4;
  localparam int PIXOFF_MSB = 3;
  localparam int BASE_W = 10;
  localparam int FB_DELTA_MSB = 10;
  localparam int FB_SIZE_MSB = 8;
  // Pixel bus layout
  localparam int PIX_W = 18;
  localparam int UPPER_LSB = 9;
  // Reset values
  localparam logic [31:0] OUT_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] MEM_REG_RST = 32'h0000_0000;
  // Decoded output configuration
  typedef struct packed {
    logic upper_pixel_drive_en;
    logic lower_pixel_drive_en;
    logic pixel_clock_out_en;
    logic sixteen_bit_packing_sel;
    logic depth_8bpp;
  } dofb_cfg_t;
  // Memory read request toward the memory controller
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } dofb_req_t;
  // Fetch engine states
  typedef enum logic [1:0] {
    F_IDLE = 2'b00,
    F_REQ = 2'b01,
    F_WAIT = 2'b10
  } dofb_fetch_t;
endpackage : dofb_pkg
`default_nettype wire

// >>> hdl/dofb_fifo.sv
// Module: parameterised word FIFO between memory fetch and pixel output
`default_nettype none
module dofb_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("dofb_fifo depth must be a power of two of at least 2");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;
  // Handshakes and honest full/empty
  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end
  // Pointers and fill count
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + AW'(push);
      rd_ptr_reg <= rd_ptr_reg + AW'(pop);
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : dofb_fifo
`default_nettype wire

// >>> hdl/dofb_fetch.sv
// Module: line-by-line frame buffer fetch address generator
`default_nettype none
module dofb_fetch
  import dofb_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Scan events
  input wire logic frame_start,
  input wire logic line_start,
  // Programmed layout
  input wire logic [APER_W-1:ADDR_LSB] frame_addr,
  input wire logic [FB_DELTA_MSB:0] line_delta_dw,
  input wire logic [FB_SIZE_MSB:0] line_qwords,
  input wire logic [BASE_W-1:0] aperture_base_field,
  // Back-pressure and memory handshake
  input wire logic fifo_room,
  input wire logic mem_gnt,
  input wire logic mem_rvalid,
  output dofb_req_t req,
  output logic word_keep,
  output logic busy
);
  dofb_fetch_t state_reg;
  logic [APER_W-1:0] base_reg;
  logic [APER_W-1:0] cur_reg;
  logic [FB_SIZE_MSB+1:0] left_reg;
  logic first_reg;
  logic stale_reg;
  logic [APER_W-1:0] next_base;
  // Next line = previous line offset plus delta in DWORDs
  assign next_base = first_reg ? base_reg : base_reg + {9'h000, line_delta_dw, 2'b00};
  assign word_keep = mem_rvalid & ~stale_reg;
  assign busy = (state_reg != F_IDLE) | (left_reg != '0);
  // Line base tracking; address part applied at frame scan start
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      base_reg <= '0;
      first_reg <= 1'b1;
    end else if (frame_start) begin
      base_reg <= {frame_addr, 4'h0};
      first_reg <= 1'b1;
    end else if (line_start) begin
      base_reg <= next_base;
      first_reg <= 1'b0;
    end
  end
  // Word address and words left in the line; offset wraps inside the aperture
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cur_reg <= '0;
      left_reg <= '0;
    end else if (line_start) begin
      cur_reg <= next_base;
      left_reg <= {line_qwords, 1'b0};
    end else if (state_reg == F_REQ && mem_gnt) begin
      cur_reg <= cur_reg + 22'h000004;
      left_reg <= left_reg - 10'h001;
    end
  end
  // Request sequencing, one word outstanding
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= F_IDLE;
      req <= '0;
      stale_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        F_IDLE: begin
          stale_reg <= 1'b0;
          if (!line_start && left_reg != '0 && fifo_room) begin
            state_reg <= F_REQ;
            req.valid <= 1'b1;
            req.addr <= {aperture_base_field, cur_reg};
          end
        end
        F_REQ: begin
          if (mem_gnt) begin
            state_reg <= F_WAIT;
            req.valid <= 1'b0;
            stale_reg <= line_start;
          end else if (line_start) begin
            state_reg <= F_IDLE;
            req.valid <= 1'b0;
          end
        end
        F_WAIT: begin
          if (mem_rvalid) begin
            state_reg <= F_IDLE;
          end else if (line_start) begin
            stale_reg <= 1'b1;
          end
        end
        default: begin
          state_reg <= F_IDLE;
          req.valid <= 1'b0;
        end
      endcase
    end
  end
endmodule : dofb_fetch
`default_nettype wire

// >>> hdl/dofb_display_out.sv
// Module: display output stage with frame buffer offset registers
`default_nettype none
module dofb_display_out
  import dofb_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter int FIFO_WIDTH = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Scan timing from the timing generator
  input wire logic frame_start,
  input wire logic line_start,
  input wire logic display_active,
  // Aperture base from the memory controller
  input wire logic [BASE_W-1:0] aperture_base_field,
  // Memory read port
  output logic mem_req,
  output logic [31:0] mem_addr,
  input wire logic mem_gnt,
  input wire logic mem_rvalid,
  input wire logic [FIFO_WIDTH-1:0] mem_rdata,
  // Display pins
  output logic [PIX_W-1:0] pixel_data,
  output logic pixel_clk_out
);
  if (FIFO_WIDTH != 32) begin : g_chk_w
    $error("dofb_display_out packs pixels from 32-bit words only");
  end
  if (FIFO_DEPTH < 2) begin : g_chk_d
    $error("dofb_display_out needs a FIFO of at least two words");
  end

  // Register storage
  logic [31:0] out_cfg_reg;
  logic [31:0] fb_start_reg;
  logic [31:0] cb_start_reg;
  logic [31:0] cur_start_reg;
  logic [31:0] vid_start_reg;
  logic [31:0] line_delta_reg;
  logic [31:0] buf_size_reg;
  logic [APER_W-1:ADDR_LSB] fb_addr_act_reg;
  logic [APER_W-1:ADDR_LSB] frame_addr_sel;
  logic fb_pending_reg;
  logic [31:0] rdata_next;
  logic fb_wr;
  dofb_cfg_t cfg;

  // Pixel path state
  logic pclk_phase_reg;
  logic pixel_clk_reg;
  logic [PIX_W-1:0] pixel_reg;
  logic [31:0] word_reg;
  logic have_word_reg;
  logic [1:0] slot_reg;
  logic [3:0] skip_reg;
  logic advance;
  logic consume;
  logic last_slot;
  logic [15:0] pix16;
  logic [7:0] pix8;
  logic [PIX_W-1:0] pix_fmt;

  // Fetch and FIFO wiring
  dofb_req_t req;
  logic word_keep;
  logic fetch_busy;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [FIFO_WIDTH-1:0] fifo_out_data;

  // Expand one 16-bit pixel to the 18-bit bus in the selected packing
  function automatic logic [PIX_W-1:0] pack16(input logic [15:0] p, input logic fmt555);
    logic [PIX_W-1:0] r;
    r = '0;
    if (fmt555) begin
      r = {p[14:10], p[14], p[9:5], p[9], p[4:0], p[4]};
    end else begin
      r = {p[15:11], p[15], p[10:5], p[4:0], p[4]};
    end
    return r;
  endfunction : pack16

  // Apply the two pixel bus drive enables
  function automatic logic [PIX_W-1:0] drive_mask(input logic [PIX_W-1:0] d, input dofb_cfg_t c);
    logic [PIX_W-1:0] r;
    r = d;
    if (!c.upper_pixel_drive_en) begin
      r[PIX_W-1:UPPER_LSB] = '0;
    end
    if (!c.lower_pixel_drive_en) begin
      r[UPPER_LSB-1:0] = '0;
    end
    return r;
  endfunction : drive_mask

  // Decoded configuration bits
  assign cfg.upper_pixel_drive_en = out_cfg_reg[CFG_UPPER_BIT];
  assign cfg.lower_pixel_drive_en = out_cfg_reg[CFG_LOWER_BIT];
  assign cfg.pixel_clock_out_en = out_cfg_reg[CFG_PCLK_BIT];
  assign cfg.sixteen_bit_packing_sel = out_cfg_reg[CFG_FMT_BIT];
  assign cfg.depth_8bpp = out_cfg_reg[CFG_DEPTH_BIT];
  assign fb_wr = reg_wr && (reg_addr == OFF_FB_START);

  // Output configuration; reserved bits are dropped on write
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_cfg_reg <= OUT_CFG_RST;
    end else if (reg_wr && reg_addr == OFF_OUT_CFG) begin
      out_cfg_reg <= reg_wdata & OUT_CFG_MASK;
    end
  end

  // Frame buffer start offset, bits 21:0 only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fb_start_reg <= MEM_REG_RST;
    end else if (fb_wr) begin
      fb_start_reg <= reg_wdata & OFFSET_MASK;
    end
  end

  // Remaining memory organisation registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cb_start_reg <= MEM_REG_RST;
      cur_start_reg <= MEM_REG_RST;
      vid_start_reg <= MEM_REG_RST;
      line_delta_reg <= MEM_REG_RST;
      buf_size_reg <= MEM_REG_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        OFF_CB_START: cb_start_reg <= reg_wdata & OFFSET_MASK;
        OFF_CUR_START: cur_start_reg <= reg_wdata & OFFSET_MASK;
        OFF_VID_START: vid_start_reg <= reg_wdata & OFFSET_MASK;
        OFF_LINE_DELTA: line_delta_reg <= reg_wdata & DELTA_MASK;
        OFF_BUF_SIZE: buf_size_reg <= reg_wdata & BUF_SIZE_MASK;
        default: begin
        end
      endcase
    end
  end

  // Pending address part: set by a nonzero write, consumed at frame start
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fb_pending_reg <= 1'b0;
    end else if (fb_wr && (reg_wdata & OFFSET_MASK) != 32'h0000_0000) begin
      fb_pending_reg <= 1'b1;
    end else if (frame_start) begin
      fb_pending_reg <= 1'b0;
    end
  end

  // Address part that the scan actually uses
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fb_addr_act_reg <= '0;
    end else if (frame_start && fb_pending_reg) begin
      fb_addr_act_reg <= fb_start_reg[APER_W-1:ADDR_LSB];
    end
  end

  // Fetch sees the pending address part in the very frame start that applies it
  assign frame_addr_sel = fb_pending_reg ? fb_start_reg[APER_W-1:ADDR_LSB] : fb_addr_act_reg;

  // Read decode; unmapped and reserved locations read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (reg_addr)
      OFF_OUT_CFG: rdata_next = out_cfg_reg;
      OFF_FB_START: rdata_next = fb_start_reg;
      OFF_CB_START: rdata_next = cb_start_reg;
      OFF_CUR_START: rdata_next = cur_start_reg;
      OFF_VID_START: rdata_next = vid_start_reg;
      OFF_LINE_DELTA: rdata_next = line_delta_reg;
      OFF_BUF_SIZE: rdata_next = buf_size_reg;
      OFF_STATUS: rdata_next = {8'h00, fetch_busy, fb_pending_reg, fb_addr_act_reg, 4'h0};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // Read data stands for the one cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // Line fetch engine
  dofb_fetch u_fetch (
    .clk(clk),
    .resetn(resetn),
    .frame_start(frame_start),
    .line_start(line_start),
    .frame_addr(frame_addr_sel),
    .line_delta_dw(line_delta_reg[FB_DELTA_MSB:0]),
    .line_qwords(buf_size_reg[FB_SIZE_MSB:0]),
    .aperture_base_field(aperture_base_field),
    .fifo_room(fifo_in_ready),
    .mem_gnt(mem_gnt),
    .mem_rvalid(mem_rvalid),
    .req(req),
    .word_keep(word_keep),
    .busy(fetch_busy)
  );
  assign mem_req = req.valid;
  assign mem_addr = req.addr;

  // Pixel word FIFO, flushed at each line start
  dofb_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .flush(line_start),
    .in_valid(word_keep),
    .in_ready(fifo_in_ready),
    .in_data(mem_rdata),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );
  assign fifo_out_ready = ~have_word_reg & ~line_start;

  // Pixel clock: free divide by two, gated low when disabled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pclk_phase_reg <= 1'b0;
      pixel_clk_reg <= 1'b0;
    end else begin
      pclk_phase_reg <= ~pclk_phase_reg;
      pixel_clk_reg <= ~pclk_phase_reg & cfg.pixel_clock_out_en;
    end
  end
  assign pixel_clk_out = pixel_clk_reg;

  // Pixel stepping: one pixel per pixel clock, extra pops while skipping
  assign advance = pclk_phase_reg & display_active;
  assign consume = have_word_reg & (advance | (skip_reg != 4'h0));
  assign last_slot = cfg.depth_8bpp ? (slot_reg == 2'b11) : (slot_reg == 2'b01);

  // Current word and slot within it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      word_reg <= 32'h0000_0000;
      have_word_reg <= 1'b0;
      slot_reg <= 2'b00;
    end else if (line_start) begin
      have_word_reg <= 1'b0;
      slot_reg <= 2'b00;
    end else if (!have_word_reg) begin
      if (fifo_out_valid) begin
        word_reg <= fifo_out_data;
        have_word_reg <= 1'b1;
        slot_reg <= 2'b00;
      end
    end else if (consume) begin
      have_word_reg <= ~last_slot;
      slot_reg <= slot_reg + 2'b01;
    end
  end

  // Pixel offset within the first fetch takes effect at the next line start, without waiting for frame start
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      skip_reg <= 4'h0;
    end else if (line_start) begin
      if (cfg.depth_8bpp) begin
        skip_reg <= fb_start_reg[PIXOFF_MSB:0];
      end else begin
        skip_reg <= {1'b0, fb_start_reg[PIXOFF_MSB:1]};
      end
    end else if (consume && skip_reg != 4'h0) begin
      skip_reg <= skip_reg - 4'h1;
    end
  end

  // Select the pixel of the current slot
  assign pix16 = slot_reg[0] ? word_reg[31:16] : word_reg[15:0];
  always_comb begin
    unique case (slot_reg)
      2'b00: pix8 = word_reg[7:0];
      2'b01: pix8 = word_reg[15:8];
      2'b10: pix8 = word_reg[23:16];
      2'b11: pix8 = word_reg[31:24];
    endcase
  end

  // Format by depth; packing bit only counts in 16-bpp mode
  always_comb begin
    if (cfg.depth_8bpp) begin
      pix_fmt = {10'h000, pix8};
    end else begin
      pix_fmt = pack16(pix16, cfg.sixteen_bit_packing_sel);
    end
  end

  // Pixel bus register; low outside the active area or on underrun
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pixel_reg <= '0;
    end else if (!display_active) begin
      pixel_reg <= '0;
    end else if (advance) begin
      if (have_word_reg && skip_reg == 4'h0) begin
        pixel_reg <= drive_mask(pix_fmt, cfg);
      end else begin
        pixel_reg <= '0;
      end
    end else begin
      pixel_reg <= drive_mask(pixel_reg, cfg);
    end
  end
  assign pixel_data = pixel_reg;

endmodule : dofb_display_out
`default_nettype wire

// >>> sim/dofb_display_out_properties.sv
// Checker: port-level properties of the display output stage
`default_nettype none
module dofb_display_out_properties
  import dofb_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Scan and memory port
  input wire logic line_start,
  input wire logic [BASE_W-1:0] aperture_base_field,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic mem_gnt,
  // Display pins
  input wire logic [PIX_W-1:0] pixel_data,
  input wire logic pixel_clk_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [31:0] cfg_reg;
  logic [31:0] prev_reg;
  logic have_reg;
  // Shadow of the output configuration register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_reg <= OUT_CFG_RST;
    end else if (reg_wr && reg_addr == OFF_OUT_CFG) begin
      cfg_reg <= reg_wdata;
    end
  end
  // Last granted word address within the current line
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      have_reg <= 1'b0;
      prev_reg <= 32'h0;
    end else if (line_start) begin
      have_reg <= 1'b0;
    end else if (mem_req && mem_gnt) begin
      have_reg <= 1'b1;
      prev_reg <= mem_addr;
    end
  end
  // A fresh pixel produced under a settled configuration
  sequence s_new_pixel;
    cfg_reg == $past(cfg_reg) && cfg_reg == $past(cfg_reg, 2) && pixel_data != $past(pixel_data);
  endsequence
  sequence s_granted;
    mem_req && mem_gnt;
  endsequence
  a_upper_forced_low: assert property (!cfg_reg[CFG_UPPER_BIT] && !$past(cfg_reg[CFG_UPPER_BIT])
    |-> pixel_data[PIX_W-1:UPPER_LSB] == 9'h000) else $error("upper pixel bits driven while disabled");
  a_lower_forced_low: assert property (!cfg_reg[CFG_LOWER_BIT] && !$past(cfg_reg[CFG_LOWER_BIT])
    |-> pixel_data[UPPER_LSB-1:0] == 9'h000) else $error("lower pixel bits driven while disabled");
  a_pclk_held_low: assert property (!cfg_reg[CFG_PCLK_BIT] && !$past(cfg_reg[CFG_PCLK_BIT])
    |-> !pixel_clk_out) else $error("pixel clock runs while disabled");
  a_rgb565_pack: assert property (s_new_pixel ##0 (!cfg_reg[CFG_DEPTH_BIT] && !cfg_reg[CFG_FMT_BIT])
    |-> pixel_data[12] == pixel_data[17] && pixel_data[0] == pixel_data[5]) else $error("bad 565 packing");
  a_rgb555_pack: assert property (s_new_pixel ##0 (!cfg_reg[CFG_DEPTH_BIT] && cfg_reg[CFG_FMT_BIT])
    |-> pixel_data[12] == pixel_data[17] && pixel_data[6] == pixel_data[11] && pixel_data[0] == pixel_data[5])
    else $error("bad 555 packing");
  a_depth8_clear: assert property (s_new_pixel ##0 cfg_reg[CFG_DEPTH_BIT]
    |-> pixel_data[PIX_W-1:8] == 10'h000) else $error("8-bpp pixel has upper bits");
  a_unmapped_zero: assert property (reg_rd && (reg_addr == 16'h831C || reg_addr == 16'h832C)
    |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
  a_fb_reserved_zero: assert property (reg_rd && reg_addr == OFF_FB_START
    |=> reg_rdata[31:22] == 10'h000) else $error("reserved start bits read nonzero");
  a_aperture_base: assert property (mem_req |-> mem_addr[31:22] == aperture_base_field)
    else $error("fetch outside aperture");
  a_req_drops: assert property (s_granted |=> !mem_req [*2])
    else $error("request not dropped after grant");
  a_word_step: assert property ($rose(mem_req) && have_reg
    |-> mem_addr[21:0] == prev_reg[21:0] + 22'h4) else $error("word address step not 4");
endmodule : dofb_display_out_properties
`default_nettype wire

// >>> sim/dofb_mem_model.sv
// Memory controller model: grants reads and answers with address-tagged words
`default_nettype none
module dofb_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Request side
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic slow,
  // Answer side
  output logic mem_gnt,
  output logic mem_rvalid,
  output logic [31:0] mem_rdata
);
  logic [31:0] addr_reg;
  logic [2:0] wait_reg;
  logic pend_reg;
  // One read in flight; idle data changes every cycle so stale values never match
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mem_gnt <= 1'b0;
      mem_rvalid <= 1'b0;
      mem_rdata <= 32'h0;
      addr_reg <= 32'h0;
      wait_reg <= 3'h0;
      pend_reg <= 1'b0;
    end else begin
      mem_gnt <= 1'b0;
      mem_rvalid <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_reg <= wait_reg + 3'h1;
      if (!pend_reg && mem_req && !mem_gnt && wait_reg >= (slow ? 3'h3 : 3'h0)) begin
        mem_gnt <= 1'b1;
        addr_reg <= mem_addr;
        pend_reg <= 1'b1;
        wait_reg <= 3'h0;
      end
      if (pend_reg && wait_reg >= (slow ? 3'h4 : 3'h1)) begin
        mem_rvalid <= 1'b1;
        mem_rdata <= {~addr_reg[15:0], addr_reg[15:0]};
        pend_reg <= 1'b0;
        wait_reg <= 3'h0;
      end
      // A request withdrawn before the grant was seen is not taken
      if (mem_gnt && !mem_req) begin
        pend_reg <= 1'b0;
        wait_reg <= 3'h0;
      end
    end
  end
endmodule : dofb_mem_model
`default_nettype wire

// >>> sim/testbench.sv
// Testbench: registers, fetch addressing and pixel output of the display stage
`default_nettype none
module testbench
  import dofb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] BASE = 10'h2A5;
  logic clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
  logic frame_start = 1'b0, line_start = 1'b0, display_active = 1'b0;
  logic [15:0] reg_addr = 16'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, mem_addr, mem_rdata, a;
  logic mem_req, mem_gnt, mem_rvalid, pixel_clk_out, pclk_seen;
  logic [PIX_W-1:0] pixel_data, pix_or;
  int bad_count = 0, n_compared = 0, grants = 0;
  logic [15:0] offs [7] = '{OFF_FB_START, OFF_CB_START, OFF_CUR_START, OFF_VID_START,
                            OFF_LINE_DELTA, OFF_BUF_SIZE, OFF_OUT_CFG};
  logic [31:0] masks [7] = '{OFFSET_MASK, OFFSET_MASK, OFFSET_MASK, OFFSET_MASK,
                             DELTA_MASK, BUF_SIZE_MASK, OUT_CFG_MASK};
  logic [15:0] cfgs [7] = '{16'h3004, 16'h3006, 16'h3005, 16'h3007, 16'h2004, 16'h1004, 16'h3000};
  logic [17:0] zmask [7] = '{18'h0, 18'h0, 18'h3FF00, 18'h3FF00, 18'h001FF, 18'h3FE00, 18'h0};
  always #5 clk = ~clk;
  // Design and memory partner
  dofb_display_out #(.FIFO_DEPTH(8), .FIFO_WIDTH(32)) DUT (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_start(frame_start), .line_start(line_start),
    .display_active(display_active), .aperture_base_field(BASE), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
    .pixel_data(pixel_data), .pixel_clk_out(pixel_clk_out));
  dofb_mem_model u_mem (.clk(clk), .resetn(resetn), .mem_req(mem_req), .mem_addr(mem_addr),
    .slow(slow), .mem_gnt(mem_gnt), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
  // Count accepted reads
  always @(posedge clk) if (mem_req === 1'b1 && mem_gnt === 1'b1) grants++;
  task wrap_up;
    $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task wr(input logic [15:0] ad, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rchk(input string n, input logic [15:0] ad, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(n, reg_rdata, e);
  endtask : rchk
  // One-cycle frame or line start pulse
  task scan(input bit f);
    @(posedge clk);
    if (f) frame_start <= 1'b1;
    else line_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
    line_start <= 1'b0;
  endtask : scan
  task wait_req;
    int i;
    for (i = 0; i < 300; i++) begin
      @(posedge clk);
      if (mem_req === 1'b1) break;
    end
    if (i == 300) begin
      bad_count++;
      wrap_up();
    end else a = mem_addr;
  endtask : wait_req
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rchk("fb_start", OFF_FB_START, MEM_REG_RST);
    rchk("hole", 16'h831C, 32'h0);
    for (int k = 0; k < 7; k++) begin
      wr(offs[k], 32'hFFFF_FFFF);
      rchk("reg mask", offs[k], masks[k]);
    end
    wr(OFF_LINE_DELTA, 32'h0000_0010);
    wr(OFF_BUF_SIZE, 32'h0000_0010);
    wr(OFF_FB_START, 32'h0000_0123);
    wr(OFF_STATUS, 32'hFFFF_FFFF);
    rchk("pending", OFF_STATUS, 32'h0040_0000);
    scan(1);
    rchk("applied", OFF_STATUS, 32'h0000_0120);
    wr(OFF_FB_START, 32'h0);
    rchk("zero kept", OFF_STATUS, 32'h0000_0120);
    // First line fills the buffer until it refuses, then drains with a slow memory
    #1 grants = 0;
    scan(0);
    wait_req();
    check("line0", a, {BASE, 22'h120});
    repeat (150) @(posedge clk);
    check("fill", (grants == 8 || grants == 9), 32'h1);
    check("full stop", mem_req, 32'h0);
    slow <= 1'b1;
    display_active <= 1'b1;
    repeat (400) @(posedge clk);
    check("words", grants, 32'd32);
    display_active <= 1'b0;
    slow <= 1'b0;
    scan(0);
    wait_req();
    check("line1", a, {BASE, 22'h160});
    wr(OFF_FB_START, 32'h0000_0208);
    scan(1);
    scan(0);
    wait_req();
    check("pan", a, {BASE, 22'h200});
    // Output modes
    for (int k = 0; k < 7; k++) begin
      wr(OFF_OUT_CFG, {16'h0, cfgs[k]});
      scan(1);
      scan(0);
      display_active <= 1'b1;
      repeat (12) @(posedge clk);
      pix_or = '0;
      pclk_seen = 1'b0;
      for (int j = 0; j < 70; j++) begin
        @(posedge clk);
        #1;
        pix_or = pix_or | pixel_data;
        pclk_seen = pclk_seen | pixel_clk_out;
      end
      display_active <= 1'b0;
      check("zero bits", pix_or & zmask[k], 32'h0);
      check("some pixel", |pix_or, 32'h1);
      check("pclk", pclk_seen, cfgs[k][CFG_PCLK_BIT]);
    end
    // Reset in mid-run clears the registers
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rchk("cfg after reset", OFF_OUT_CFG, OUT_CFG_RST);
    wrap_up();
  end
endmodule : testbench
bind dofb_display_out dofb_display_out_properties u_props (
  .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_start(line_start),
  .aperture_base_field(aperture_base_field), .mem_req(mem_req), .mem_addr(mem_addr),
  .mem_gnt(mem_gnt), .pixel_data(pixel_data), .pixel_clk_out(pixel_clk_out));
`default_nettype wire
